// >>> logic/umc_modem_ctrl.v
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "umc_defines.vh"
// Behaviour
// - infrared select routes transmit and receive through the infrared codec while loopback is off
// - infrared transmit output idles low while infrared mode is off or loopback is on
// - on 16-style bus the interrupt-type bit picks push-pull or open-source
// - on 68-style bus the interrupt output is always open-drain
// - loopback detaches tx, rx and four modem inputs from pins
// - receiver and transmitter interrupts work unchanged in loopback
// - loopback modem interrupts come from control low bits, gated by enable
// - in loopback carrier-detect comes from control bit 3
// - in loopback ring-indicator comes from control bit 2
// - request-to-send pin is high when bit 1 is 0, low when 1
// - data-terminal-ready pin is high when bit 0 is 0, low when 1
// - loopback is off after reset
// - infrared select clear after reset gives the standard serial pins
module umc_modem_ctrl (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire        bus16_sel,
    input  wire        tx_ser,
    input  wire        tx_ir_pulse,
    input  wire        rx_event,
    input  wire        tx_event,
    input  wire        rx_pin,
    input  wire        rx_ir,
    input  wire        cts_pin_n,
    input  wire        dsr_pin_n,
    input  wire        ri_pin_n,
    input  wire        cd_pin_n,
    output wire        tx_pin,
    output wire        tx_ir_pin,
    output wire        rx_core,
    output wire        rts_n,
    output wire        dtr_n,
    output wire        clk_div4,
    output wire        int_pin_o,
    output wire        int_pin_oe,
    output wire        irq
);
    reg  [7:0]  modem_control_reg;
    reg  [7:0]  interrupt_enable_reg;
    reg  [`UMC_IRQ_WIDTH-1:0] irq_status_r;
    reg  [`UMC_IRQ_WIDTH-1:0] irq_mask_r;
    reg  [3:0]  ms_prev_r;
    reg  [3:0]  ms_delta_r;
    reg         dph_wr_r;
    reg  [11:0] dph_addr_r;
    wire [4:0]  pins_s;
    wire        cts_core;
    wire        dsr_core;
    wire        ri_core;
    wire        cd_core;
    wire [3:0]  ms_now;
    wire [3:0]  ms_chg;
    wire        modem_evt;
    wire        uart_int;
    wire        aph_ok;
    wire        wr_mc;
    wire        wr_ie;
    wire        wr_st;
    wire        wr_mk;
    wire        rd_ms;
    wire [`UMC_IRQ_WIDTH-1:0] evt;
    wire [`UMC_IRQ_WIDTH-1:0] w1c;
    wire [7:0]  mc_nxt;
    wire [7:0]  ie_nxt;
    wire [`UMC_IRQ_WIDTH-1:0] mk_nxt;
    wire [`UMC_IRQ_WIDTH-1:0] st_nxt;

    // is the address decoded to one of our words
    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `UMC_ADDR_MODEM_CTRL) || (a == `UMC_ADDR_IRQ_STATUS) ||
                     (a == `UMC_ADDR_IRQ_MASK)   || (a == `UMC_ADDR_MODEM_STAT) ||
                     (a == `UMC_ADDR_INT_ENABLE);
        end
    endfunction

    // pin inputs cross into hclk before use
    umc_sync2 #(
        .W (5)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d_in    ({rx_pin, cts_pin_n, dsr_pin_n, ri_pin_n, cd_pin_n}),
        .q_out   (pins_s)
    );

    // infrared receive is a codec output on hclk, needs no sync
    umc_pin_mux u_mux (
        .loop_en     (modem_control_reg[`UMC_MC_LOOP]),
        .ir_en       (modem_control_reg[`UMC_MC_IR_EN]),
        .tx_ser      (tx_ser),
        .tx_ir_pulse (tx_ir_pulse),
        .rx_pin_s    (pins_s[4]),
        .rx_ir_s     (rx_ir),
        .rts_n       (rts_n),
        .dtr_n       (dtr_n),
        .aux_ring    (modem_control_reg[`UMC_MC_AUX_RING]),
        .aux_carrier (modem_control_reg[`UMC_MC_AUX_CARRIER]),
        .cts_pin_n_s (pins_s[3]),
        .dsr_pin_n_s (pins_s[2]),
        .ri_pin_n_s  (pins_s[1]),
        .cd_pin_n_s  (pins_s[0]),
        .tx_pin      (tx_pin),
        .tx_ir_pin   (tx_ir_pin),
        .rx_core     (rx_core),
        .cts_core    (cts_core),
        .dsr_core    (dsr_core),
        .ri_core     (ri_core),
        .cd_core     (cd_core)
    );

    // handshake outputs straight from control bits, inverted onto low-true pins
    assign rts_n    = !modem_control_reg[`UMC_MC_RTS];
    assign dtr_n    = !modem_control_reg[`UMC_MC_DTR];
    assign clk_div4 = modem_control_reg[`UMC_MC_CLK_SEL];

    // bus: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign aph_ok    = hsel && hready && htrans[1];

    // capture the address phase for the following data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr_r   <= 1'b0;
            dph_addr_r <= 12'h000;
        end else if (hready) begin
            dph_wr_r   <= aph_ok && hwrite;
            dph_addr_r <= haddr;
        end
    end

    assign wr_mc = dph_wr_r && (dph_addr_r == `UMC_ADDR_MODEM_CTRL);
    assign wr_ie = dph_wr_r && (dph_addr_r == `UMC_ADDR_INT_ENABLE);
    assign wr_st = dph_wr_r && (dph_addr_r == `UMC_ADDR_IRQ_STATUS);
    assign wr_mk = dph_wr_r && (dph_addr_r == `UMC_ADDR_IRQ_MASK);
    assign rd_ms = aph_ok && !hwrite && (haddr == `UMC_ADDR_MODEM_STAT);

    // next values; a read right behind a write sees the new word, not the stale one
    assign mc_nxt = wr_mc ? hwdata[7:0] : modem_control_reg;
    assign ie_nxt = wr_ie ? hwdata[7:0] : interrupt_enable_reg;
    assign mk_nxt = wr_mk ? hwdata[`UMC_IRQ_WIDTH-1:0] : irq_mask_r;

    // control and enable registers; loopback and infrared clear at reset
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            modem_control_reg    <= `UMC_MC_RESET;
            interrupt_enable_reg <= `UMC_IE_RESET;
            irq_mask_r           <= {`UMC_IRQ_WIDTH{1'b0}};
        end else begin
            modem_control_reg    <= mc_nxt;
            interrupt_enable_reg <= ie_nxt;
            irq_mask_r           <= mk_nxt;
        end
    end

    // status inputs, from pins or from the control bits in loopback
    assign ms_now = {cd_core, ri_core, dsr_core, cts_core};
    // ring delta on trailing edge, others on any change
    assign ms_chg = {ms_now[3] ^ ms_prev_r[3], ms_prev_r[2] & !ms_now[2],
                     ms_now[1] ^ ms_prev_r[1], ms_now[0] ^ ms_prev_r[0]};

    // delta bits sticky until the status word is read; new change wins
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ms_prev_r  <= 4'h0;
            ms_delta_r <= 4'h0;
        end else begin
            ms_prev_r  <= ms_now;
            ms_delta_r <= (rd_ms ? 4'h0 : ms_delta_r) | ms_chg;
        end
    end

    // events gated by enable bits, identical in loopback
    assign modem_evt = |ms_chg && interrupt_enable_reg[`UMC_IE_MODEM];
    assign evt = {tx_event && interrupt_enable_reg[`UMC_IE_TX],
                  rx_event && interrupt_enable_reg[`UMC_IE_RX],
                  modem_evt};
    assign w1c = wr_st ? hwdata[`UMC_IRQ_WIDTH-1:0] : {`UMC_IRQ_WIDTH{1'b0}};

    // sticky status: write one clears, a same-cycle event wins
    assign st_nxt = (irq_status_r & ~w1c) | evt;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            irq_status_r <= {`UMC_IRQ_WIDTH{1'b0}};
        else
            irq_status_r <= st_nxt;
    end

    assign irq      = |(irq_status_r & irq_mask_r);
    assign uart_int = irq;

    // interrupt pin drive style: push-pull, open-source, or open-drain
    // open-source only ever drives high, so its level is fixed at one
    assign int_pin_o  = bus16_sel ? (modem_control_reg[`UMC_MC_INT_TYPE] | uart_int) : 1'b0;
    assign int_pin_oe = !bus16_sel ? uart_int :
                        (modem_control_reg[`UMC_MC_INT_TYPE] ? uart_int : 1'b1);

    // read data registered for the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (aph_ok && !hwrite && mapped(haddr)) begin
            case (haddr)
                `UMC_ADDR_MODEM_CTRL: hrdata <= {24'h00_0000, mc_nxt};
                `UMC_ADDR_INT_ENABLE: hrdata <= {24'h00_0000, ie_nxt};
                `UMC_ADDR_IRQ_STATUS: hrdata <= {29'h0000_0000, st_nxt};
                `UMC_ADDR_IRQ_MASK:   hrdata <= {29'h0000_0000, mk_nxt};
                `UMC_ADDR_MODEM_STAT: hrdata <= {24'h00_0000, ms_now, ms_delta_r | ms_chg};
                default:              hrdata <= 32'h0000_0000;
            endcase
        end else if (aph_ok && !hwrite) begin
            hrdata <= 32'h0000_0000;
        end
    end
endmodule

// >>> logic/umc_defines.vh
`ifndef UMC_DEFINES_VH
`define UMC_DEFINES_VH
// register byte addresses
`define UMC_ADDR_MODEM_CTRL   12'h010
`define UMC_ADDR_IRQ_STATUS   12'h014
`define UMC_ADDR_IRQ_MASK     12'h018
`define UMC_ADDR_MODEM_STAT   12'h01c
`define UMC_ADDR_INT_ENABLE   12'h020
// modem control fields
`define UMC_MC_DTR            0
`define UMC_MC_RTS            1
`define UMC_MC_AUX_RING       2
`define UMC_MC_AUX_CARRIER    3
`define UMC_MC_LOOP           4
`define UMC_MC_INT_TYPE       5
`define UMC_MC_IR_EN          6
`define UMC_MC_CLK_SEL        7
`define UMC_MC_RESET          8'h00
`define UMC_MC_WMASK          8'h7f
// modem status byte: low nibble deltas, high nibble cts dsr ri cd
`define UMC_MS_CTS            4
`define UMC_MS_DSR            5
`define UMC_MS_RI             6
`define UMC_MS_CD             7
// interrupt status bits
`define UMC_IRQ_MODEM         0
`define UMC_IRQ_RX            1
`define UMC_IRQ_TX            2
`define UMC_IRQ_WIDTH         3
// interrupt enable fields
`define UMC_IE_RX             0
`define UMC_IE_TX             1
`define UMC_IE_MODEM          3
`define UMC_IE_RESET          8'h00
`endif

// >>> logic/umc_sync2.v
`timescale 1ns/10ps
// two-flop synchroniser for a vector of pin inputs
module umc_sync2 #(
    parameter W = 5
) (
    input  wire         hclk,
    input  wire         hresetn,
    input  wire [W-1:0] d_in,
    output wire [W-1:0] q_out
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    // first stage is read only by the second
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= {W{1'b1}};
            sync_r <= {W{1'b1}};
        end else begin
            meta_r <= d_in;
            sync_r <= meta_r;
        end
    end
    assign q_out = sync_r;
endmodule

// >>> logic/umc_pin_mux.v
`timescale 1ns/10ps
// routes serial and modem lines between pins, infrared codec and loopback
module umc_pin_mux (
    input  wire loop_en,
    input  wire ir_en,
    input  wire tx_ser,
    input  wire tx_ir_pulse,
    input  wire rx_pin_s,
    input  wire rx_ir_s,
    input  wire rts_n,
    input  wire dtr_n,
    input  wire aux_ring,
    input  wire aux_carrier,
    input  wire cts_pin_n_s,
    input  wire dsr_pin_n_s,
    input  wire ri_pin_n_s,
    input  wire cd_pin_n_s,
    output wire tx_pin,
    output wire tx_ir_pin,
    output wire rx_core,
    output wire cts_core,
    output wire dsr_core,
    output wire ri_core,
    output wire cd_core
);
    // loopback parks tx pins idle: high for serial, low for infrared
    assign tx_pin    = (loop_en || ir_en) ? 1'b1 : tx_ser;
    assign tx_ir_pin = (ir_en && !loop_en) ? tx_ir_pulse : 1'b0;
    // receive path: loop takes the raw transmit stream
    assign rx_core = loop_en ? tx_ser : (ir_en ? rx_ir_s : rx_pin_s);
    // modem status as active-high, from pins or the control bits
    assign cts_core = loop_en ? !rts_n       : !cts_pin_n_s;
    assign dsr_core = loop_en ? !dtr_n       : !dsr_pin_n_s;
    assign ri_core  = loop_en ? aux_ring     : !ri_pin_n_s;
    assign cd_core  = loop_en ? aux_carrier  : !cd_pin_n_s;
endmodule

// >>> tb/umc_far_end.sv
`timescale 1ns/10ps
// modem stand-in: echoes tx back to rx and crosses the handshakes back,
// so a loopback that leaks rx, ring or carrier to the pins shows up as a different value; leaked cts and dsr echo the same value
module umc_far_end (
    input  wire tx_pin,
    input  wire rts_n,
    input  wire dtr_n,
    input  wire ring_n,
    output wire rx_pin,
    output wire cts_pin_n,
    output wire dsr_pin_n,
    output wire ri_pin_n,
    output wire cd_pin_n
);
    // all pins driven at all times, no release state on this side
    assign rx_pin    = tx_pin;
    assign cts_pin_n = rts_n;
    assign dsr_pin_n = dtr_n;
    assign ri_pin_n  = ring_n;
    assign cd_pin_n  = ring_n;
endmodule

// >>> tb/umc_modem_ctrl_asserts.sv
`timescale 1ns/10ps
`include "umc_defines.vh"
// port checker; mirrors the control byte from bus writes
module umc_modem_ctrl_asserts (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [11:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        bus16_sel,
    input wire        tx_ser,
    input wire        tx_ir_pulse,
    input wire        rx_ir,
    input wire        tx_pin,
    input wire        tx_ir_pin,
    input wire        rx_core,
    input wire        rts_n,
    input wire        dtr_n,
    input wire        int_pin_o,
    input wire        int_pin_oe,
    input wire        irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire       take = hsel & hready & htrans[1];
    reg        wr_r;
    reg  [7:0] mc_r;
    // write lands at the end of the data phase, same edge as the design
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_r <= 1'b0;
            mc_r <= 8'h00;
        end else begin
            if (wr_r && hready) mc_r <= hwdata[7:0];
            wr_r <= take & hwrite & (haddr == `UMC_ADDR_MODEM_CTRL);
        end
    end
    property p_rts; rts_n == !mc_r[1]; endproperty
    a_rts: assert property (p_rts) else $error("rts_n level wrong");
    property p_dtr; dtr_n == !mc_r[0]; endproperty
    a_dtr: assert property (p_dtr) else $error("dtr_n level wrong");
    property p_txp; tx_pin == (mc_r[4] | mc_r[6] | tx_ser); endproperty
    a_txp: assert property (p_txp) else $error("tx_pin route wrong");
    property p_irt; tx_ir_pin == (mc_r[6] & ~mc_r[4] & tx_ir_pulse); endproperty
    a_irt: assert property (p_irt) else $error("tx_ir_pin wrong");
    property p_rxl; mc_r[4] |-> rx_core == tx_ser; endproperty
    a_rxl: assert property (p_rxl) else $error("loop rx wrong");
    property p_rxi; (mc_r[6] && !mc_r[4]) |-> rx_core == rx_ir; endproperty
    a_rxi: assert property (p_rxi) else $error("ir rx wrong");
    property p_i16; (bus16_sel && !mc_r[5]) |-> int_pin_oe && int_pin_o == irq; endproperty
    a_i16: assert property (p_i16) else $error("push-pull irq pin wrong");
    property p_ios; (bus16_sel && mc_r[5]) |-> int_pin_oe == irq && int_pin_o; endproperty
    a_ios: assert property (p_ios) else $error("open-source irq pin wrong");
    property p_i68; !bus16_sel |-> int_pin_oe == irq && !int_pin_o; endproperty
    a_i68: assert property (p_i68) else $error("open-drain irq pin wrong");
    property p_rd; take && !hwrite && haddr == `UMC_ADDR_MODEM_CTRL
        |=> hrdata == {24'h00_0000, mc_r}; endproperty
    a_rd: assert property (p_rd) else $error("control readback wrong");
    c_loop: cover property (mc_r[4] && irq);
    c_ir: cover property (mc_r[6] && !mc_r[4]);
    c_od: cover property (!bus16_sel && int_pin_oe);
endmodule

// >>> tb/tb_umc_modem_ctrl.sv
`timescale 1ns/10ps
`include "umc_defines.vh"
module tb_umc_modem_ctrl;
    reg         hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, bus16_sel = 1;
    reg         tx_ser = 0, tx_ir_pulse = 1, rx_event = 0, tx_event = 0, rx_ir = 1, ring_n = 1;
    reg  [11:0] haddr = 12'h000;
    reg  [1:0]  htrans = 2'h0;
    reg  [31:0] hwdata = 32'h0000_0000;
    reg  [31:0] rd;
    wire [31:0] hrdata;
    wire        hready, hresp, tx_pin, tx_ir_pin, rx_core, rts_n, dtr_n, int_pin_o, int_pin_oe;
    wire        irq, rx_pin, cts_pin_n, dsr_pin_n, ri_pin_n, cd_pin_n, clk_div4;
    integer     mismatches = 0, num_checks = 0, cycles = 0;
    always #50 hclk = ~hclk;
    umc_modem_ctrl i_umc_modem_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .bus16_sel(bus16_sel), .tx_ser(tx_ser), .tx_ir_pulse(tx_ir_pulse), .rx_event(rx_event),
        .tx_event(tx_event), .rx_pin(rx_pin), .rx_ir(rx_ir), .cts_pin_n(cts_pin_n),
        .dsr_pin_n(dsr_pin_n), .ri_pin_n(ri_pin_n), .cd_pin_n(cd_pin_n), .tx_pin(tx_pin),
        .tx_ir_pin(tx_ir_pin), .rx_core(rx_core), .rts_n(rts_n), .dtr_n(dtr_n),
        .clk_div4(clk_div4), .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe), .irq(irq));
    umc_far_end i_umc_far_end (.tx_pin(tx_pin), .rts_n(rts_n), .dtr_n(dtr_n), .ring_n(ring_n),
        .rx_pin(rx_pin), .cts_pin_n(cts_pin_n), .dsr_pin_n(dsr_pin_n), .ri_pin_n(ri_pin_n),
        .cd_pin_n(cd_pin_n));
    task close_out;
        begin
            $display("checks %0d mismatches %0d", num_checks, mismatches);
            if (mismatches == 0 && num_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // a hang anywhere counts as a mismatch
    always @(posedge hclk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            mismatches = mismatches + 1;
            close_out;
        end
    end
    task cmp(input [8*10-1:0] nm, input [31:0] exp, input [31:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("ERROR %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // single transfer: address phase, then data phase, each held until hready
    task bus(input [11:0] a, input w, input [31:0] d);
        begin
            @(posedge hclk);
            hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
            @(posedge hclk);
            while (hready !== 1'b1) @(posedge hclk);
            hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
            @(posedge hclk);
            while (hready !== 1'b1) @(posedge hclk);
            rd = hrdata;
        end
    endtask
    task rchk(input [11:0] a, input [31:0] exp);
        begin
            bus(a, 1'b0, 32'h0000_0000);
            cmp("rdata", exp, rd);
            cmp("hresp", 32'h0000_0000, hresp);
        end
    endtask
    // three settled cycles let the synchronised pins catch up
    task mode(input [7:0] m, input [2:0] e);
        begin
            bus(`UMC_ADDR_MODEM_CTRL, 1'b1, {24'h00_0000, m});
            repeat (3) @(posedge hclk);
            @(negedge hclk);
            cmp("tx_pin", e[2], tx_pin);
            cmp("tx_ir_pin", e[1], tx_ir_pin);
            cmp("rx_core", e[0], rx_core);
            cmp("rts_n", !m[1], rts_n);
            cmp("dtr_n", !m[0], dtr_n);
            cmp("clk_div4", m[7], clk_div4);
        end
    endtask
    task ipin(input e_o, input e_oe);
        begin
            @(negedge hclk);
            cmp("int_o", e_o, int_pin_o);
            cmp("int_oe", e_oe, int_pin_oe);
        end
    endtask
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(`UMC_ADDR_MODEM_CTRL, 32'h0000_0000);
        rchk(`UMC_ADDR_INT_ENABLE, 32'h0000_0000);
        rchk(12'h100, 32'h0000_0000);
        mode(8'h00, 3'b000);
        mode(8'h03, 3'b000);
        mode(8'h80, 3'b000);
        mode(8'h40, 3'b111);
        @(posedge hclk) tx_ir_pulse <= 1'b0;
        ipin(1'b0, 1'b1);
        cmp("tx_ir_idle", 1'b0, tx_ir_pin);
        @(posedge hclk) tx_ir_pulse <= 1'b1;
        mode(8'h50, 3'b100);
        bus(`UMC_ADDR_INT_ENABLE, 1'b1, 32'h0000_000b);
        bus(`UMC_ADDR_IRQ_MASK, 1'b1, 32'h0000_0007);
        bus(`UMC_ADDR_IRQ_STATUS, 1'b1, 32'h0000_0007);
        mode(8'h1c, 3'b100);
        bus(`UMC_ADDR_MODEM_STAT, 1'b0, 32'h0000_0000);
        cmp("loop_stat", 32'h0000_00c0, rd & 32'h0000_00f0);
        rchk(`UMC_ADDR_IRQ_STATUS, 32'h0000_0001);
        ipin(1'b1, 1'b1);
        @(posedge hclk) rx_event <= 1'b1;
        tx_event <= 1'b1;
        @(posedge hclk) rx_event <= 1'b0;
        tx_event <= 1'b0;
        rchk(`UMC_ADDR_IRQ_STATUS, 32'h0000_0007);
        cmp("irq", 32'h0000_0001, irq);
        ring_n <= 1'b0;
        mode(8'h33, 3'b100);
        ipin(1'b1, 1'b1);
        bus(`UMC_ADDR_MODEM_STAT, 1'b0, 32'h0000_0000);
        cmp("loop_stat", 32'h0000_0030, rd & 32'h0000_00f0);
        bus16_sel <= 1'b0;
        ipin(1'b0, 1'b1);
        bus(`UMC_ADDR_IRQ_STATUS, 1'b1, 32'h0000_0007);
        rchk(`UMC_ADDR_IRQ_STATUS, 32'h0000_0000);
        cmp("irq", 32'h0000_0000, irq);
        ipin(1'b0, 1'b0);
        @(posedge hclk) bus16_sel <= 1'b1;
        ipin(1'b1, 1'b0);
        close_out;
    end
endmodule
bind umc_modem_ctrl umc_modem_ctrl_asserts i_umc_modem_ctrl_asserts (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .bus16_sel(bus16_sel), .tx_ser(tx_ser),
    .tx_ir_pulse(tx_ir_pulse), .rx_ir(rx_ir), .tx_pin(tx_pin), .tx_ir_pin(tx_ir_pin),
    .rx_core(rx_core), .rts_n(rts_n), .dtr_n(dtr_n), .int_pin_o(int_pin_o),
    .int_pin_oe(int_pin_oe), .irq(irq));
